// >>> core/ebc_defines.vh
// Register indices, field positions and command codes of the event and counter block
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH
// Register indices; byte address is four times the index
`define EBC_IDX_TRIG_LOW 8'h06
`define EBC_IDX_TRIG_HIGH 8'h07
`define EBC_IDX_MAIN_CTRL 8'h08
`define EBC_IDX_AUX_CTRL 8'h09
`define EBC_IDX_AUX_CMD 8'h0a
`define EBC_IDX_MAIN_RLD_LO 8'h0c
`define EBC_IDX_MAIN_RLD_HI 8'h0d
`define EBC_IDX_AUX_RLD_LO 8'h0e
`define EBC_IDX_AUX_RLD_HI 8'h0f
`define EBC_IDX_STATUS 8'h10
`define EBC_IDX_MAIN_LO 8'h14
`define EBC_IDX_MAIN_HI 8'h15
`define EBC_IDX_AUX_VAL 8'h18
`define EBC_IDX_INT_FLAGS 8'h19
// Reset value of every writable register
`define EBC_REG_RESET 16'h0000
// Per-input trigger configuration byte
`define EBC_TRG_SYNC 4
`define EBC_TRG_MASK 5
// Main counter control fields
`define EBC_MC_PAUSE 0
`define EBC_MC_FINISH 1
`define EBC_MC_RELOAD 2
`define EBC_MC_MODE_LSB 3
`define EBC_MC_SRC_LSB 6
// Aux counter control fields
`define EBC_AC_LOAD_LSB 0
`define EBC_AC_LO_NOLOAD 3
`define EBC_AC_LO_ZRLD 4
`define EBC_AC_LO_EDGE_LSB 5
`define EBC_AC_SYNC_LOAD 8
`define EBC_AC_ARR_LSB 9
`define EBC_AC_HI_NOLOAD 11
`define EBC_AC_HI_ZRLD 12
`define EBC_AC_HI_EDGE_LSB 13
// Main counter count modes
`define EBC_MODE_RTI 3'b010
`define EBC_MODE_EXEC 3'b011
`define EBC_MODE_DET 3'b100
`define EBC_MODE_PIN 3'b101
`define EBC_MODE_LOW 3'b110
`define EBC_MODE_HIGH 3'b111
// Aux arrangement codes
`define EBC_ARR_SEP_LO 2'b00
`define EBC_ARR_TIED 2'b10
`define EBC_ARR_WIDE 2'b11
// Auxiliary command top nibble
`define EBC_CMD_INT_LO_CLR 4'h0
`define EBC_CMD_INT_HI_CLR 4'h1
`define EBC_CMD_INT_LO_SET 4'h2
`define EBC_CMD_INT_HI_SET 4'h3
`define EBC_CMD_REQ_CLR 4'h4
`define EBC_CMD_REQ_SET 4'h5
`define EBC_CMD_LOAD 4'h6
`endif

// >>> core/ebc_event_counter.v
// Trigger recognition, request flags, main and auxiliary counters behind an APB slave
`timescale 1ns/1ps
`include "ebc_defines.vh"

module ebc_event_counter (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Scan side pins
  input wire tck,
  input wire [3:0] trigger_pin,
  // Sequencer state, same clock domain
  input wire scan_data_state,
  input wire run_idle_state,
  input wire idle_cycle_command,
  input wire scan_shift_state,
  // Results
  output reg [3:0] request_flag,
  output reg [15:0] int_flag,
  output reg [3:0] edge_sense_hit,
  output reg main_zero,
  output reg aux_low_zero,
  output reg aux_high_zero
);

////////////////////////////////////////////////////////////////////////////////
// Registers and state
reg [15:0] trigger_select_low;
reg [15:0] trigger_select_high;
reg [15:0] main_counter_control;
reg [15:0] aux_counter_control;
reg [15:0] auxiliary_command;
reg [31:0] main_counter_reload;
reg [15:0] aux_low_reload;
reg [15:0] aux_high_reload;
// Live counters; reset to zero, so the first tick already passes zero
reg [31:0] main_counter;
reg [15:0] aux_counter_low;
reg [15:0] aux_counter_high;
// Two-stage synchronisers for the scan-side pins and the test clock
reg [3:0] pin_meta;
reg [3:0] pin_sync;
reg [3:0] pin_prev;
reg [3:0] pin_tck;
reg tck_meta;
reg tck_sync;
reg tck_prev;
// One-cycle strobe after a command write
reg cmd_pulse;

// Both trigger registers as one map, one byte per input
wire [31:0] sel_all = {trigger_select_high, trigger_select_low};
// Edges found in the pclk domain; each tck phase must last two pclk cycles
wire tck_rise = tck_sync & ~tck_prev;
wire [3:0] pin_fall = pin_prev & ~pin_sync;
wire [3:0] pin_rise = pin_sync & ~pin_prev;
wire [3:0] det;
// Command fields; the low byte is the flag mask
wire [3:0] cmd_op = auxiliary_command[15:12];
wire [7:0] cmd_bits = auxiliary_command[7:0];

////////////////////////////////////////////////////////////////////////////////
// Pin and TCK synchronisers, then history for edges
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pin_meta <= 4'h0;
    pin_sync <= 4'h0;
    pin_prev <= 4'h0;
    pin_tck <= 4'h0;
    tck_meta <= 1'b0;
    tck_sync <= 1'b0;
    tck_prev <= 1'b0;
  end else begin
    // First stage may go metastable; only the second stage is read
    pin_meta <= trigger_pin;
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
    tck_meta <= tck;
    tck_sync <= tck_meta;
    tck_prev <= tck_sync;
    // Level seen at the last TCK edge, for two-sample matching
    if (tck_rise) begin
      pin_tck <= pin_sync;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Per-input recognition; one config byte per input
genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : trig
    wire [7:0] cfg = sel_all[g*8 +: 8];
    // Level required at the previous tck edge
    wire want_old = cfg[7] ? cfg[6] : ~cfg[6];
    // Level now must match the low condition bit
    wire sync_hit = tck_rise & (pin_tck[g] == want_old) & (pin_sync[g] == cfg[6]);
    reg async_hit;
    // Zero passings feed the detector as well as edges
    always @* begin
      case (cfg[7:6])
        2'b00: async_hit = pin_fall[g];
        2'b01: async_hit = pin_rise[g];
        2'b10: async_hit = aux_low_zero;
        default: async_hit = aux_high_zero;
      endcase
    end
    // Masked inputs are blind during the data scan state
    assign det[g] = (cfg[`EBC_TRG_SYNC] ? sync_hit : async_hit) &
      ~(cfg[`EBC_TRG_MASK] & scan_data_state);
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Request flag setters from detectors and main zero passing
reg [3:0] req_set;
integer i;
always @* begin
  req_set = 4'h0;
  for (i = 0; i < 4; i = i + 1) begin
    req_set = req_set | ({4{det[i]}} & sel_all[i*8 +: 4]);
  end
  // Main zero passing adds pause and finish requests
  req_set[0] = req_set[0] | (main_zero & main_counter_control[`EBC_MC_PAUSE]);
  req_set[1] = req_set[1] | (main_zero & main_counter_control[`EBC_MC_FINISH]);
end

////////////////////////////////////////////////////////////////////////////////
// Main counter tick selection
wire [2:0] mc_mode = main_counter_control[`EBC_MC_MODE_LSB +: 3];
wire [1:0] mc_src = main_counter_control[`EBC_MC_SRC_LSB +: 2];
// Synchronised level of the selected pin
wire mc_pin = pin_sync[mc_src];
reg mc_tick;
always @* begin
  case (mc_mode)
    `EBC_MODE_RTI: mc_tick = tck_rise & idle_cycle_command & run_idle_state;
    `EBC_MODE_EXEC: mc_tick = tck_rise & idle_cycle_command;
    `EBC_MODE_DET: mc_tick = det[mc_src];
    `EBC_MODE_PIN: mc_tick = pin_rise[mc_src];
    `EBC_MODE_LOW: mc_tick = tck_rise & ~mc_pin;
    `EBC_MODE_HIGH: mc_tick = tck_rise & mc_pin;
    default: mc_tick = 1'b0;
  endcase
  // Shift cycles of a scan command are counted in the command modes
  if (mc_mode[2:1] == 2'b01 && scan_shift_state && tck_rise) begin
    mc_tick = 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Aux counter tick, load and arrangement
wire [2:0] lo_edge = aux_counter_control[`EBC_AC_LO_EDGE_LSB +: 3];
wire [2:0] hi_edge = aux_counter_control[`EBC_AC_HI_EDGE_LSB +: 3];
wire [2:0] ld_code = aux_counter_control[`EBC_AC_LOAD_LSB +: 3];
wire [1:0] arr = aux_counter_control[`EBC_AC_ARR_LSB +: 2];
wire lo_edge_hit = lo_edge[0] ? pin_rise[lo_edge[2:1]] : pin_fall[lo_edge[2:1]];
wire hi_edge_hit = hi_edge[0] ? pin_rise[hi_edge[2:1]] : pin_fall[hi_edge[2:1]];
// Sync loading uses the level caught at the last TCK edge
wire [3:0] ld_level = aux_counter_control[`EBC_AC_SYNC_LOAD] ? pin_tck : pin_sync;
wire ld_cond = ld_level[ld_code[2:1]] == ld_code[0];
wire cascade = arr[1];
// Low half always counts on its own edge
wire lo_tick = lo_edge_hit;
wire lo_pass = lo_tick & (aux_counter_low == 16'h0000);
// Tied and wide forms advance the high half on a low-half wrap
wire hi_tick = cascade ? lo_pass : hi_edge_hit;
wire hi_pass = hi_tick & (aux_counter_high == 16'h0000);
// Level load is held for as long as the condition holds
wire lo_ld = ld_cond & ~aux_counter_control[`EBC_AC_LO_NOLOAD];
wire hi_ld_any = (arr == `EBC_ARR_WIDE) ? lo_ld : ld_cond;
wire hi_ld = hi_ld_any & ~aux_counter_control[`EBC_AC_HI_NOLOAD] &
  (arr != `EBC_ARR_SEP_LO);
// Software load from the command's load code
wire sw_load = cmd_pulse && cmd_op == `EBC_CMD_LOAD;
// Wide form passes zero only when the whole 32 bits wrap
wire lo_zero_out = (arr == `EBC_ARR_WIDE) ? 1'b0 : lo_pass;

////////////////////////////////////////////////////////////////////////////////
// Counters; load beats count, zero passing reload optional
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    main_counter <= 32'h00000000;
    aux_counter_low <= 16'h0000;
    aux_counter_high <= 16'h0000;
    main_zero <= 1'b0;
    aux_low_zero <= 1'b0;
    aux_high_zero <= 1'b0;
  end else begin
    // Zero pulses follow one cycle after the tick that passes zero
    main_zero <= mc_tick & (main_counter == 32'h00000000);
    aux_low_zero <= lo_zero_out;
    aux_high_zero <= hi_pass;
    // Software load wins over a tick in the same cycle
    if (sw_load && cmd_bits[0]) begin
      main_counter <= main_counter_reload;
    end else if (mc_tick) begin
      if (main_counter == 32'h00000000 && main_counter_control[`EBC_MC_RELOAD]) begin
        main_counter <= main_counter_reload;
      end else begin
        main_counter <= main_counter - 32'h00000001;
      end
    end
    // Low aux: load first, then reload at zero, else count down
    if ((sw_load && cmd_bits[4]) || lo_ld) begin
      aux_counter_low <= aux_low_reload;
    end else if (lo_tick) begin
      if (lo_pass && aux_counter_control[`EBC_AC_LO_ZRLD]) begin
        aux_counter_low <= aux_low_reload;
      end else begin
        aux_counter_low <= aux_counter_low - 16'h0001;
      end
    end
    // High aux, same order of priority
    if ((sw_load && cmd_bits[5]) || hi_ld) begin
      aux_counter_high <= aux_high_reload;
    end else if (hi_tick) begin
      if (hi_pass && aux_counter_control[`EBC_AC_HI_ZRLD]) begin
        aux_counter_high <= aux_high_reload;
      end else begin
        aux_counter_high <= aux_counter_high - 16'h0001;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Flags: hardware set beats command clear in the same cycle
reg [3:0] next_request_flag;
reg [15:0] next_int_flag;
always @* begin
  next_request_flag = request_flag;
  next_int_flag = int_flag;
  // Command first, hardware sets are ORed on top
  if (cmd_pulse) begin
    case (cmd_op)
      `EBC_CMD_INT_LO_CLR: next_int_flag[5:0] = int_flag[5:0] & ~cmd_bits[5:0];
      `EBC_CMD_INT_LO_SET: next_int_flag[5:0] = int_flag[5:0] | cmd_bits[5:0];
      `EBC_CMD_INT_HI_CLR: next_int_flag[15:8] = int_flag[15:8] & ~cmd_bits;
      `EBC_CMD_INT_HI_SET: next_int_flag[15:8] = int_flag[15:8] | cmd_bits;
      `EBC_CMD_REQ_CLR: next_request_flag = request_flag & ~cmd_bits[3:0];
      `EBC_CMD_REQ_SET: next_request_flag = request_flag | cmd_bits[3:0];
      default: next_request_flag = request_flag;
    endcase
  end
  // Applied last so a same-cycle clear cannot lose an event
  next_request_flag = next_request_flag | req_set;
end

// Flag and hit registers
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    request_flag <= 4'h0;
    int_flag <= 16'h0000;
    edge_sense_hit <= 4'h0;
  end else begin
    request_flag <= next_request_flag;
    int_flag <= next_int_flag;
    // Sticky detector hits, cleared by the request-clear command
    if (cmd_pulse && cmd_op == `EBC_CMD_REQ_CLR) begin
      edge_sense_hit <= det;
    end else begin
      edge_sense_hit <= edge_sense_hit | det;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// APB decode; read data latched in setup so it comes from a flop
wire [7:0] idx = {2'b00, paddr[7:2]};
wire setup = psel & ~penable;
wire wr_take = psel & penable & pwrite;
reg [31:0] rd_mux;
reg hit;
// No wait states: every register answers in the access phase
assign pready = 1'b1;

// Read mux; the upper half of 16-bit registers reads zero
always @* begin
  hit = 1'b1;
  case (idx)
    `EBC_IDX_TRIG_LOW: rd_mux = {16'h0000, trigger_select_low};
    `EBC_IDX_TRIG_HIGH: rd_mux = {16'h0000, trigger_select_high};
    `EBC_IDX_MAIN_CTRL: rd_mux = {16'h0000, main_counter_control};
    `EBC_IDX_AUX_CTRL: rd_mux = {16'h0000, aux_counter_control};
    `EBC_IDX_AUX_CMD: rd_mux = {16'h0000, auxiliary_command};
    `EBC_IDX_MAIN_RLD_LO: rd_mux = {16'h0000, main_counter_reload[15:0]};
    `EBC_IDX_MAIN_RLD_HI: rd_mux = {16'h0000, main_counter_reload[31:16]};
    `EBC_IDX_AUX_RLD_LO: rd_mux = {16'h0000, aux_low_reload};
    `EBC_IDX_AUX_RLD_HI: rd_mux = {16'h0000, aux_high_reload};
    `EBC_IDX_STATUS: rd_mux = {24'h000000, edge_sense_hit, request_flag};
    `EBC_IDX_MAIN_LO: rd_mux = {16'h0000, main_counter[15:0]};
    `EBC_IDX_MAIN_HI: rd_mux = {16'h0000, main_counter[31:16]};
    `EBC_IDX_AUX_VAL: rd_mux = {aux_counter_high, aux_counter_low};
    `EBC_IDX_INT_FLAGS: rd_mux = {16'h0000, int_flag};
    default: begin
      rd_mux = 32'h00000000;
      hit = 1'b0;
    end
  endcase
end

// Writes land in the access phase; a command write also fires one pulse
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    trigger_select_low <= `EBC_REG_RESET;
    trigger_select_high <= `EBC_REG_RESET;
    main_counter_control <= `EBC_REG_RESET;
    aux_counter_control <= `EBC_REG_RESET;
    auxiliary_command <= `EBC_REG_RESET;
    main_counter_reload <= 32'h00000000;
    aux_low_reload <= `EBC_REG_RESET;
    aux_high_reload <= `EBC_REG_RESET;
    cmd_pulse <= 1'b0;
    prdata <= 32'h00000000;
    pslverr <= 1'b0;
  end else begin
    // Pulse a cycle late so the command register has settled
    cmd_pulse <= wr_take && idx == `EBC_IDX_AUX_CMD;
    // Sampled in setup, so read data stands through the access phase
    if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~hit;
    end
    // Writes to read-only or unmapped indices are dropped
    if (wr_take) begin
      case (idx)
        `EBC_IDX_TRIG_LOW: trigger_select_low <= pwdata[15:0];
        `EBC_IDX_TRIG_HIGH: trigger_select_high <= pwdata[15:0];
        `EBC_IDX_MAIN_CTRL: main_counter_control <= pwdata[15:0];
        `EBC_IDX_AUX_CTRL: aux_counter_control <= pwdata[15:0];
        `EBC_IDX_AUX_CMD: auxiliary_command <= pwdata[15:0];
        `EBC_IDX_MAIN_RLD_LO: main_counter_reload[15:0] <= pwdata[15:0];
        `EBC_IDX_MAIN_RLD_HI: main_counter_reload[31:16] <= pwdata[15:0];
        `EBC_IDX_AUX_RLD_LO: aux_low_reload <= pwdata[15:0];
        `EBC_IDX_AUX_RLD_HI: aux_high_reload <= pwdata[15:0];
        default: auxiliary_command <= auxiliary_command;
      endcase
    end
  end
end

endmodule

// >>> dv/ebc_event_counter_asserts.sv
// Port-level assertion checker for the event and counter block
`timescale 1ns/1ps
`include "ebc_defines.vh"
module ebc_event_counter_asserts (
  // APB side
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Results
  input wire [3:0] request_flag,
  input wire [15:0] int_flag,
  input wire main_zero
);
  ////////////////////////////////////////
  reg [15:0] mctl;
  reg [7:0] m;
  wire wr = psel && penable && pwrite;
  wire cw = wr && paddr == (`EBC_IDX_AUX_CMD << 2);
  wire rc = cw && pwdata[15:12] == 4'h4;
  // Shadow of host writes, since flags follow the last command mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mctl <= 16'h0000;
      m <= 8'h00;
    end else begin
      if (wr && paddr == (`EBC_IDX_MAIN_CTRL << 2))
        mctl <= pwdata[15:0];
      if (cw)
        m <= pwdata[7:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmd(logic [3:0] n);
    cw && pwdata[15:12] == n;
  endsequence
  chk_lo_set: assert property (s_cmd(4'h2) |->
    ##[1:3] ((int_flag[5:0] & m[5:0]) == m[5:0])) else $error("low flags not set");
  chk_lo_clr: assert property (s_cmd(4'h0) |->
    ##[1:3] ((int_flag[5:0] & m[5:0]) == 6'h00)) else $error("low flags not cleared");
  chk_hi_set: assert property (s_cmd(4'h3) |->
    ##[1:3] ((int_flag[15:8] & m) == m)) else $error("high flags not set");
  chk_hi_clr: assert property (s_cmd(4'h1) |->
    ##[1:3] ((int_flag[15:8] & m) == 8'h00)) else $error("high flags not cleared");
  chk_gap_flags: assert property (int_flag[7:6] == 2'b00)
    else $error("flags 6 and 7 changed");
  chk_flag_quiet: assert property (!$past(cw) && !$past(cw, 2) && !$past(cw, 3) |->
    $stable(int_flag)) else $error("flags moved without command");
  chk_zero_req: assert property (main_zero |->
    ##[0:2] ((request_flag[1:0] & mctl[1:0]) == mctl[1:0])) else $error("zero flag missing");
  chk_never_count: assert property (mctl[5:4] == 2'b00 && $past(mctl[5:4], 3) == 2'b00
    |-> !main_zero) else $error("counter ran in stop mode");
  chk_req_sticky: assert property ((|($past(request_flag) & ~request_flag)) |->
    $past(rc) || $past(rc, 2) || $past(rc, 3)) else $error("request flag dropped");
  chk_unmapped_err: assert property (psel && !penable && paddr == 8'h2c |=>
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  chk_no_wait: assert property (pready) else $error("wait state seen");
endmodule
bind ebc_event_counter ebc_event_counter_asserts ebc_event_counter_asserts_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .request_flag(request_flag), .int_flag(int_flag), .main_zero(main_zero));

// >>> dv/ebc_scan_side.sv
// Scan-side model: gated test clock and trigger pins
`timescale 1ns/1ps
module ebc_scan_side (
  // Control from the bench
  input wire tck_run,
  input wire [3:0] pin_set,
  // Pins toward the block
  output reg tck,
  output reg [3:0] trigger_pin
);
  // Test clock stands low outside frames, 25 pclk periods long at a fixed phase to pclk
  initial begin
    tck = 1'b0;
    // Offset keeps every tck edge off a pclk edge
    #1.25;
    forever begin
      #62.5;
      if (tck_run || tck)
        tck = ~tck;
    end
  end
  // Pins move away from pclk edges so the synchroniser sees real skew
  initial trigger_pin = 4'h0;
  always @(pin_set) begin
    trigger_pin <= #3 pin_set;
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the event and counter block
`timescale 1ns/1ps
`include "ebc_defines.vh"
module tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  reg sds = 1'b0;
  reg tck_run = 1'b0;
  reg [3:0] pin_set = 4'h0;
  reg ric = 1'b0;
  reg icc = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, tck, main_zero, aux_low_zero, aux_high_zero;
  wire [3:0] trigger_pin, request_flag, hit;
  wire [15:0] int_flag;
  integer bad_count = 0;
  integer checks = 0;
  integer mz = 0;
  integer az = 0;
  integer hz = 0;
  integer h;
  integer n;
  integer i;
  reg [31:0] q;
  reg e;
  reg [7:0] ix;
  ////////////////////////////////////////
  ebc_event_counter ebc_event_counter_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tck(tck), .trigger_pin(trigger_pin),
    .scan_data_state(sds), .run_idle_state(ric), .idle_cycle_command(icc),
    .scan_shift_state(1'b0), .request_flag(request_flag), .int_flag(int_flag),
    .edge_sense_hit(hit), .main_zero(main_zero), .aux_low_zero(aux_low_zero),
    .aux_high_zero(aux_high_zero));
  ebc_scan_side ebc_scan_side_inst (.tck_run(tck_run), .pin_set(pin_set), .tck(tck),
    .trigger_pin(trigger_pin));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Zero pulses are one cycle wide, so count them at every edge
  always @(posedge pclk) begin
    if (main_zero === 1'b1)
      mz <= mz + 1;
    if (aux_low_zero === 1'b1)
      az <= az + 1;
    if (aux_high_zero === 1'b1)
      hz <= hz + 1;
  end
  ////////////////////////////////////////
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] x, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== x) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge pclk);
  endtask
  // One APB transfer; a leading edge keeps psel from being driven twice in a step
  task apb(input [7:0] idx, input w, input [15:0] d);
    integer t;
    begin
      @(posedge pclk);
      paddr <= idx << 2;
      pwrite <= w;
      pwdata <= {16'h0000, d};
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      t = 0;
      while (pready !== 1'b1 && t < 20) begin
        t = t + 1;
        @(posedge pclk);
      end
      if (t == 20) begin
        bad_count = bad_count + 1;
        tally_and_finish;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task pin(input integer k, input v);
    begin
      pin_set[k] <= v;
      cyc(10);
    end
  endtask
  // Bounded wait for the next main zero pulse
  task wait_zero;
    begin
      n = mz;
      i = 0;
      while (mz == n && i < 3000) begin
        i = i + 1;
        cyc(1);
      end
      if (i == 3000) begin
        bad_count = bad_count + 1;
        tally_and_finish;
      end
    end
  endtask
  ////////////////////////////////////////
  task t_regs;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        ix = i[7:0] + ((i < 4) ? 8'h06 : 8'h08);
        apb(ix, 1'b0, 16'h0000);
        chk("reset val", 32'h0, q);
        apb(ix, 1'b1, 16'ha5c3);
        apb(ix, 1'b0, 16'h0000);
        chk("readback", 32'h0000a5c3, q);
        apb(ix, 1'b1, 16'h0000);
      end
      apb(8'h0b, 1'b0, 16'h0000);
      chk("unmapped err", 32'h1, {31'h0, e});
      apb(`EBC_IDX_STATUS, 1'b1, 16'hffff);
      apb(`EBC_IDX_STATUS, 1'b0, 16'h0000);
      chk("status ro", 32'h0, q);
    end
  endtask
  task t_int;
    begin
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h202b);
      cyc(3);
      chk("int lo set", 32'h002b, {16'h0, int_flag});
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h3081);
      cyc(3);
      chk("int hi set", 32'h812b, {16'h0, int_flag});
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h0009);
      cyc(3);
      chk("int lo clr", 32'h8122, {16'h0, int_flag});
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h1080);
      cyc(3);
      chk("int hi clr", 32'h0122, {16'h0, int_flag});
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h20ff);
      cyc(3);
      chk("int lo edge", 32'h013f, {16'h0, int_flag});
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h00ff);
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h10ff);
      cyc(3);
      chk("int all clr", 32'h0, {16'h0, int_flag});
    end
  endtask
  task t_async;
    begin
      apb(`EBC_IDX_TRIG_HIGH, 1'b1, 16'h0a45);
      pin_set[2] <= 1'b1;
      cyc(1);
      chk("req early", 32'h0, {28'h0, request_flag});
      cyc(9);
      chk("req rise", 32'h5, {28'h0, request_flag});
      chk("hit rise", 32'h4, {28'h0, hit});
      pin(3, 1'b1);
      chk("no fall", 32'h5, {28'h0, request_flag});
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h400f);
      pin(3, 1'b0);
      chk("req fall", 32'ha, {28'h0, request_flag});
      chk("hit fall", 32'h8, {28'h0, hit});
    end
  endtask
  task t_mask;
    begin
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h400f);
      apb(`EBC_IDX_TRIG_HIGH, 1'b1, 16'h2a45);
      sds <= 1'b1;
      pin(3, 1'b1);
      pin(3, 1'b0);
      chk("masked", 32'h0, {28'h0, hit});
      sds <= 1'b0;
      pin(3, 1'b1);
      pin(3, 1'b0);
      chk("unmasked", 32'h8, {28'h0, hit});
      apb(`EBC_IDX_TRIG_HIGH, 1'b1, 16'h0000);
      pin(2, 1'b0);
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h400f);
    end
  endtask
  task t_sync;
    begin
      apb(`EBC_IDX_TRIG_LOW, 1'b1, 16'hd100);
      tck_run <= 1'b1;
      cyc(120);
      chk("sync low", 32'h0, {28'h0, hit});
      pin(1, 1'b1);
      cyc(80);
      chk("sync high", 32'h2, {28'h0, hit});
      chk("sync req", 32'h1, {28'h0, request_flag});
      tck_run <= 1'b0;
      apb(`EBC_IDX_TRIG_LOW, 1'b1, 16'h0000);
      pin(1, 1'b0);
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h400f);
    end
  endtask
  task t_main;
    begin
      apb(`EBC_IDX_MAIN_RLD_LO, 1'b1, 16'h0003);
      apb(`EBC_IDX_MAIN_CTRL, 1'b1, 16'h00bd);
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h6001);
      tck_run <= 1'b1;
      pin(3, 1'b1);
      n = mz;
      cyc(200);
      chk("idle count", n, mz);
      pin(3, 1'b0);
      pin_set[2] <= 1'b1;
      wait_zero;
      pin(2, 1'b0);
      chk("pause only", 32'h1, {28'h0, request_flag});
      apb(`EBC_IDX_MAIN_LO, 1'b0, 16'h0000);
      chk("reloaded", 32'h3, q);
      tck_run <= 1'b0;
      apb(`EBC_IDX_MAIN_CTRL, 1'b1, 16'h0000);
    end
  endtask
  task t_exec;
    begin
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h400f);
      apb(`EBC_IDX_MAIN_CTRL, 1'b1, 16'h0012);
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h6001);
      icc <= 1'b1;
      tck_run <= 1'b1;
      n = mz;
      cyc(200);
      chk("rti idle", n, mz);
      ric <= 1'b1;
      wait_zero;
      chk("rti finish", 32'h2, {28'h0, request_flag});
      ric <= 1'b0;
      apb(`EBC_IDX_MAIN_CTRL, 1'b1, 16'h001a);
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h6001);
      wait_zero;
      icc <= 1'b0;
      tck_run <= 1'b0;
      apb(`EBC_IDX_MAIN_HI, 1'b0, 16'h0000);
      chk("exec wrap", 32'hffff, q);
      apb(`EBC_IDX_MAIN_CTRL, 1'b1, 16'h0000);
    end
  endtask
  task t_aux;
    begin
      apb(`EBC_IDX_AUX_RLD_LO, 1'b1, 16'h0002);
      apb(`EBC_IDX_AUX_CTRL, 1'b1, 16'h0233);
      apb(`EBC_IDX_AUX_CMD, 1'b1, 16'h6010);
      n = az;
      h = hz;
      for (i = 0; i < 2; i = i + 1) begin
        pin(0, 1'b1);
        pin(0, 1'b0);
      end
      chk("aux early", n, az);
      pin(0, 1'b1);
      pin(0, 1'b0);
      chk("aux zero", n + 1, az);
      chk("hi zero", h + 1, hz);
      apb(`EBC_IDX_AUX_VAL, 1'b0, 16'h0000);
      chk("aux reload", 32'h2, {16'h0, q[15:0]});
      pin(1, 1'b1);
      pin(0, 1'b1);
      pin(0, 1'b0);
      apb(`EBC_IDX_AUX_VAL, 1'b0, 16'h0000);
      chk("aux level", 32'h2, {16'h0, q[15:0]});
      pin(1, 1'b0);
      apb(`EBC_IDX_AUX_CTRL, 1'b1, 16'h0000);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_int;
    t_async;
    t_mask;
    t_sync;
    t_main;
    t_exec;
    t_aux;
    tally_and_finish;
  end
endmodule
